// File: rtl/bsou_pkg.sv
// Shared types and constants of the barrel shifter operand unit
package bsou_pkg;

   localparam int unsigned WORD_W       = 32;
   localparam int unsigned AMT_W        = 8;
   localparam int unsigned ROT_W        = 5;
   localparam int unsigned BYTE_W       = 8;
   localparam logic [7:0]  WORD_LEN     = 8'h20;
   localparam logic [7:0]  WORD_LEN_P1  = 8'h21;
   localparam logic [31:0] IMM_CARRY_MIN = 32'h0000_00FF;
   localparam logic        CARRY_RST    = 1'b0;
   localparam logic [31:0] RESULT_RST   = 32'h0000_0000;

   // Shift kinds of a register operand
   typedef enum logic [2:0] {
      BSOU_LOGICAL_LEFT_SHIFT   = 3'h0,
      BSOU_LOGICAL_RIGHT_SHIFT  = 3'h1,
      BSOU_ARITH_RIGHT_SHIFT    = 3'h2,
      BSOU_ROTATE_RIGHT         = 3'h3,
      BSOU_ROTATE_THROUGH_CARRY = 3'h4
   } bsou_shift_t;

   // Immediate forms
   typedef enum logic [1:0] {
      BSOU_IMM_ROTATED  = 2'h0,
      BSOU_IMM_REP_0_2  = 2'h1,
      BSOU_IMM_REP_1_3  = 2'h2,
      BSOU_IMM_REP_ALL  = 2'h3
   } bsou_imm_form_t;

   // One flexible second operand request
   typedef struct packed {
      logic           is_imm;
      bsou_imm_form_t imm_form;
      logic [7:0]     imm_byte;
      logic [4:0]     imm_rot;
      logic [31:0]    src;
      bsou_shift_t    shift_kind;
      logic [7:0]     shift_amt;
      logic           flag_set;
   } bsou_req_t;

   // Result of the operand path
   typedef struct packed {
      logic [31:0] operand;
      logic        carry;
      logic        carry_upd;
   } bsou_res_t;

endpackage : bsou_pkg

// File: rtl/bsou_top.sv
// Flexible second operand decoder and barrel shifter
`timescale 1ns/1ps

// One rotate-right stage of the barrel shifter
module bsou_rot_stage #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned STEP  = 1
) (
   input  wire logic [WIDTH-1:0] data_i,
   input  wire logic             en_i,
   output logic      [WIDTH-1:0] data_o
);

   always_comb begin
      data_o = data_i;
      if (en_i) begin
         data_o = {data_i[STEP-1:0], data_i[WIDTH-1:STEP]};
      end
   end

endmodule : bsou_rot_stage

module bsou_top (
   input  wire logic              REF_CLK_I,
   input  wire logic              SYS_RST_I,
   input  wire logic              REQ_VALID_I,
   input  wire bsou_pkg::bsou_req_t REQ_I,
   input  wire logic              CARRY_WR_I,
   input  wire logic              CARRY_WR_VAL_I,
   output logic                   RES_VALID_O,
   output bsou_pkg::bsou_res_t    RES_O,
   output logic                   CARRY_O
);

   logic               carry_r;
   logic               res_valid_r;
   bsou_pkg::bsou_res_t res_r;
   bsou_pkg::bsou_res_t res_nxt;
   logic [31:0]        imm_val;
   logic [63:0]        rot_pair;
   logic [7:0]         amt;
   logic [4:0]         amt_lo;
   logic [4:0]         amt_neg;
   logic               amt_zero;
   logic               amt_big;
   logic [31:0]        fill_mask;
   logic [31:0]        keep_mask;
   logic [31:0]        rr_1;
   logic [31:0]        rr_2;
   logic [31:0]        rr_3;
   logic [31:0]        rr_4;
   logic [31:0]        rr_5;
   logic [31:0]        rl_1;
   logic [31:0]        rl_2;
   logic [31:0]        rl_3;
   logic [31:0]        rl_4;
   logic [31:0]        rl_5;
   logic [31:0]        asr_val;
   logic               asr_c;
   logic [31:0]        lsr_val;
   logic               lsr_c;
   logic [31:0]        lsl_val;
   logic               lsl_c;
   logic [31:0]        ror_val;
   logic               ror_c;
   logic [31:0]        rrx_val;
   logic               rrx_c;
   logic [31:0]        sh_val;
   logic               sh_c;
   logic               sh_upd;

   always_comb begin
      rot_pair = {32'h0000_0000, 24'h00_0000, REQ_I.imm_byte} << REQ_I.imm_rot;
      imm_val  = rot_pair[31:0] | rot_pair[63:32];
      case (REQ_I.imm_form)
         bsou_pkg::BSOU_IMM_ROTATED: begin
            imm_val = rot_pair[31:0] | rot_pair[63:32];
         end
         bsou_pkg::BSOU_IMM_REP_0_2: begin
            imm_val = {8'h00, REQ_I.imm_byte, 8'h00, REQ_I.imm_byte};
         end
         bsou_pkg::BSOU_IMM_REP_1_3: begin
            imm_val = {REQ_I.imm_byte, 8'h00, REQ_I.imm_byte, 8'h00};
         end
         bsou_pkg::BSOU_IMM_REP_ALL: begin
            imm_val = {4{REQ_I.imm_byte}};
         end
         default: begin
            imm_val = rot_pair[31:0] | rot_pair[63:32];
         end
      endcase
   end

   // Shift amount split and fill masks
   always_comb begin
      amt       = REQ_I.shift_amt;
      amt_lo    = amt[4:0];
      amt_neg   = 5'h00 - amt_lo;
      amt_zero  = (amt == 8'h00);
      amt_big   = (amt >= bsou_pkg::WORD_LEN);
      fill_mask = 32'hFFFF_FFFF >> amt_lo;
      keep_mask = 32'hFFFF_FFFF << amt_lo;
   end

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0001)
   ) u_rr_0 (
      .data_i (REQ_I.src),
      .en_i   (amt_lo[0]),
      .data_o (rr_1)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0002)
   ) u_rr_1 (
      .data_i (rr_1),
      .en_i   (amt_lo[1]),
      .data_o (rr_2)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0004)
   ) u_rr_2 (
      .data_i (rr_2),
      .en_i   (amt_lo[2]),
      .data_o (rr_3)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0008)
   ) u_rr_3 (
      .data_i (rr_3),
      .en_i   (amt_lo[3]),
      .data_o (rr_4)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0010)
   ) u_rr_4 (
      .data_i (rr_4),
      .en_i   (amt_lo[4]),
      .data_o (rr_5)
   );

   // Right rotator by word minus length
   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0001)
   ) u_rl_0 (
      .data_i (REQ_I.src),
      .en_i   (amt_neg[0]),
      .data_o (rl_1)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0002)
   ) u_rl_1 (
      .data_i (rl_1),
      .en_i   (amt_neg[1]),
      .data_o (rl_2)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0004)
   ) u_rl_2 (
      .data_i (rl_2),
      .en_i   (amt_neg[2]),
      .data_o (rl_3)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0008)
   ) u_rl_3 (
      .data_i (rl_3),
      .en_i   (amt_neg[3]),
      .data_o (rl_4)
   );

   bsou_rot_stage #(
      .WIDTH (bsou_pkg::WORD_W),
      .STEP  (32'h0000_0010)
   ) u_rl_4 (
      .data_i (rl_4),
      .en_i   (amt_neg[4]),
      .data_o (rl_5)
   );

   always_comb begin
      asr_val = (rr_5 & fill_mask) | ({32{REQ_I.src[31]}} & ~fill_mask);
      asr_c   = rr_5[31];
      if (amt_big) begin
         asr_val = {32{REQ_I.src[31]}};
         asr_c   = REQ_I.src[31];
      end
   end

   always_comb begin
      lsr_val = rr_5 & fill_mask;
      lsr_c   = rr_5[31];
      if (amt_big) begin
         lsr_val = 32'h0000_0000;
         lsr_c   = (amt == bsou_pkg::WORD_LEN) ? REQ_I.src[31] : 1'b0;
      end
   end

   always_comb begin
      lsl_val = rl_5 & keep_mask;
      lsl_c   = rl_5[0];
      if (amt_big) begin
         lsl_val = 32'h0000_0000;
         lsl_c   = (amt == bsou_pkg::WORD_LEN) ? REQ_I.src[0] : 1'b0;
      end
   end

   always_comb begin
      ror_val = rr_5;
      ror_c   = rr_5[31];
   end

   always_comb begin
      rrx_val = {carry_r, REQ_I.src[31:1]};
      rrx_c   = REQ_I.src[0];
   end

   always_comb begin
      sh_val = REQ_I.src;
      sh_c   = carry_r;
      sh_upd = !amt_zero;
      case (REQ_I.shift_kind)
         bsou_pkg::BSOU_ARITH_RIGHT_SHIFT: begin
            sh_val = asr_val;
            sh_c   = asr_c;
         end
         bsou_pkg::BSOU_LOGICAL_RIGHT_SHIFT: begin
            sh_val = lsr_val;
            sh_c   = lsr_c;
         end
         bsou_pkg::BSOU_LOGICAL_LEFT_SHIFT: begin
            sh_val = lsl_val;
            sh_c   = lsl_c;
         end
         bsou_pkg::BSOU_ROTATE_RIGHT: begin
            sh_val = ror_val;
            sh_c   = ror_c;
         end
         bsou_pkg::BSOU_ROTATE_THROUGH_CARRY: begin
            sh_val = rrx_val;
            sh_c   = rrx_c;
            sh_upd = 1'b1;
         end
         default: begin
            sh_val = REQ_I.src;
            sh_upd = 1'b0;
         end
      endcase
   end

   always_comb begin
      res_nxt = '0;
      if (REQ_I.is_imm) begin
         res_nxt.operand = imm_val;
         res_nxt.carry   = carry_r;
         if (REQ_I.flag_set && REQ_I.imm_form == bsou_pkg::BSOU_IMM_ROTATED
             && imm_val > bsou_pkg::IMM_CARRY_MIN) begin
            res_nxt.carry     = imm_val[31];
            res_nxt.carry_upd = 1'b1;
         end
      end else begin
         res_nxt.operand = sh_val;
         res_nxt.carry_upd = REQ_I.flag_set && sh_upd;
         res_nxt.carry     = res_nxt.carry_upd ? sh_c : carry_r;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         res_r       <= '{operand: bsou_pkg::RESULT_RST, carry: bsou_pkg::CARRY_RST,
                          carry_upd: 1'b0};
         res_valid_r <= 1'b0;
      end else begin
         res_valid_r     <= REQ_VALID_I;
         res_r.operand   <= res_nxt.operand;
         res_r.carry     <= res_nxt.carry;
         res_r.carry_upd <= REQ_VALID_I && res_nxt.carry_upd;
      end
   end

   always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         carry_r <= bsou_pkg::CARRY_RST;
      end else if (REQ_VALID_I && res_nxt.carry_upd) begin
         carry_r <= res_nxt.carry;
      end else if (CARRY_WR_I) begin
         carry_r <= CARRY_WR_VAL_I;
      end
   end

   assign RES_VALID_O = res_valid_r;
   assign RES_O       = res_r;
   assign CARRY_O     = carry_r;

endmodule : bsou_top

// File: testbench/bsou_top_monitor.sv
// Port checker of the operand unit
`timescale 1ns/1ps
module bsou_top_monitor (
   input wire logic                REF_CLK_I,
   input wire logic                SYS_RST_I,
   input wire logic                REQ_VALID_I,
   input wire bsou_pkg::bsou_req_t REQ_I,
   input wire logic                CARRY_WR_I,
   input wire logic                CARRY_WR_VAL_I,
   input wire logic                RES_VALID_O,
   input wire bsou_pkg::bsou_res_t RES_O,
   input wire logic                CARRY_O
);
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   // Register request without shift
   sequence s_noshift;
      REQ_VALID_I && !REQ_I.is_imm && REQ_I.shift_amt == 8'h00
      && REQ_I.shift_kind != bsou_pkg::BSOU_ROTATE_THROUGH_CARRY;
   endsequence
   sequence s_rep_all;
      REQ_VALID_I && REQ_I.is_imm && REQ_I.imm_form == bsou_pkg::BSOU_IMM_REP_ALL;
   endsequence
   sequence s_rrx;
      REQ_VALID_I && !REQ_I.is_imm
      && REQ_I.shift_kind == bsou_pkg::BSOU_ROTATE_THROUGH_CARRY;
   endsequence
   a_rrx_insert: assert property (s_rrx |=>
      RES_O.operand == {$past(CARRY_O), $past(REQ_I.src[31:1])}) else $error("bad carry rotate");
   a_answer_next: assert property (REQ_VALID_I |=> RES_VALID_O)
      else $error("no answer");
   a_no_spurious: assert property (!REQ_VALID_I |=> !RES_VALID_O)
      else $error("spurious answer");
   a_carry_hold: assert property (!REQ_VALID_I && !CARRY_WR_I |=> $stable(CARRY_O))
      else $error("carry moved");
   a_carry_write: assert property (!REQ_VALID_I && CARRY_WR_I |=>
      CARRY_O == $past(CARRY_WR_VAL_I)) else $error("carry write lost");
   a_carry_follows: assert property (RES_VALID_O && RES_O.carry_upd |->
      CARRY_O == RES_O.carry) else $error("carry flag differs");
   a_noflag_keep: assert property (REQ_VALID_I && !REQ_I.flag_set |=>
      !RES_O.carry_upd) else $error("carry loaded");
   a_zero_pass: assert property (s_noshift |=> RES_O.operand == $past(REQ_I.src)
      && !RES_O.carry_upd) else $error("zero shift changed");
   a_rep_all: assert property (s_rep_all |=>
      RES_O.operand == {4{$past(REQ_I.imm_byte)}}) else $error("bad replicate");
endmodule : bsou_top_monitor
bind bsou_top bsou_top_monitor u_mon (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
   .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .CARRY_WR_I(CARRY_WR_I),
   .CARRY_WR_VAL_I(CARRY_WR_VAL_I), .RES_VALID_O(RES_VALID_O), .RES_O(RES_O),
   .CARRY_O(CARRY_O));

// File: testbench/bsou_top_tb.sv
// Self-checking bench of the operand unit
`timescale 1ns/1ps
module bsou_top_tb;
   localparam bsou_pkg::bsou_shift_t LL = bsou_pkg::BSOU_LOGICAL_LEFT_SHIFT;
   localparam bsou_pkg::bsou_shift_t LR = bsou_pkg::BSOU_LOGICAL_RIGHT_SHIFT;
   localparam bsou_pkg::bsou_shift_t AR = bsou_pkg::BSOU_ARITH_RIGHT_SHIFT;
   localparam bsou_pkg::bsou_shift_t RR = bsou_pkg::BSOU_ROTATE_RIGHT;
   localparam bsou_pkg::bsou_shift_t RX = bsou_pkg::BSOU_ROTATE_THROUGH_CARRY;
   logic                clk, rst, vld, wr, wv, fs, cy, rv, co;
   bsou_pkg::bsou_req_t req;
   bsou_pkg::bsou_res_t res;
   int                  fail_count, compares;
   bsou_top DUT (.REF_CLK_I(clk), .SYS_RST_I(rst), .REQ_VALID_I(vld), .REQ_I(req),
      .CARRY_WR_I(wr), .CARRY_WR_VAL_I(wv), .RES_VALID_O(rv), .RES_O(res), .CARRY_O(co));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic go(input logic [31:0] eo, input logic ec, input logic eu);
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
      if (eu) cy = ec;
      chk(rv, 1'b1);
      chk(res.operand, eo);
      chk(res.carry_upd, eu);
      chk(res.carry, cy);
      chk(co, cy);
   endtask : go
   task automatic rg(input bsou_pkg::bsou_shift_t k, input logic [7:0] a,
      input logic [31:0] s, input logic [31:0] eo, input logic ec, input logic eu);
      @(negedge clk);
      req = '{1'b0, bsou_pkg::BSOU_IMM_ROTATED, 8'h00, 5'h00, s, k, a, fs};
      go(eo, ec, eu);
   endtask : rg
   task automatic im(input bsou_pkg::bsou_imm_form_t f, input logic [7:0] b,
      input logic [4:0] r, input logic [31:0] eo, input logic ec, input logic eu);
      @(negedge clk);
      req = '{1'b1, f, b, r, 32'h0000_0000, LL, 8'h00, fs};
      go(eo, ec, eu);
   endtask : im
   task automatic t_imm;
      fs = 1'b1;
      im(bsou_pkg::BSOU_IMM_ROTATED, 8'hFF, 5'h18, 32'hFF00_0000, 1'b1, 1'b1);
      im(bsou_pkg::BSOU_IMM_ROTATED, 8'h01, 5'h08, 32'h0000_0100, 1'b0, 1'b1);
      im(bsou_pkg::BSOU_IMM_ROTATED, 8'h81, 5'h1F, 32'h8000_0040, 1'b1, 1'b1);
      im(bsou_pkg::BSOU_IMM_ROTATED, 8'hAB, 5'h00, 32'h0000_00AB, 1'b0, 1'b0);
      im(bsou_pkg::BSOU_IMM_REP_0_2, 8'h5A, 5'h00, 32'h005A_005A, 1'b0, 1'b0);
      im(bsou_pkg::BSOU_IMM_REP_1_3, 8'h5A, 5'h00, 32'h5A00_5A00, 1'b0, 1'b0);
      im(bsou_pkg::BSOU_IMM_REP_ALL, 8'h5A, 5'h00, 32'h5A5A_5A5A, 1'b0, 1'b0);
   endtask : t_imm
   task automatic t_shift;
      fs = 1'b1;
      rg(AR, 8'h01, 32'h8000_0001, 32'hC000_0000, 1'b1, 1'b1);
      rg(AR, 8'h20, 32'h8000_0001, 32'hFFFF_FFFF, 1'b1, 1'b1);
      rg(AR, 8'h28, 32'h7FFF_FFFE, 32'h0000_0000, 1'b0, 1'b1);
      rg(LR, 8'h01, 32'h8000_0001, 32'h4000_0000, 1'b1, 1'b1);
      rg(LR, 8'h20, 32'h8000_0001, 32'h0000_0000, 1'b1, 1'b1);
      rg(LR, 8'h21, 32'h8000_0001, 32'h0000_0000, 1'b0, 1'b1);
      rg(LL, 8'h01, 32'h8000_0001, 32'h0000_0002, 1'b1, 1'b1);
      rg(LL, 8'h1F, 32'h8000_0001, 32'h8000_0000, 1'b0, 1'b1);
      rg(LL, 8'h20, 32'h8000_0001, 32'h0000_0000, 1'b1, 1'b1);
      rg(LL, 8'h21, 32'h8000_0001, 32'h0000_0000, 1'b0, 1'b1);
      rg(RR, 8'h04, 32'h8000_0001, 32'h1800_0000, 1'b0, 1'b1);
      rg(RR, 8'h20, 32'h8000_0001, 32'h8000_0001, 1'b1, 1'b1);
      rg(RR, 8'h24, 32'h8000_0001, 32'h1800_0000, 1'b0, 1'b1);
      rg(RX, 8'h01, 32'h8000_0001, 32'h4000_0000, 1'b1, 1'b1);
      rg(RX, 8'h01, 32'h8000_0001, 32'hC000_0000, 1'b1, 1'b1);
      rg(LL, 8'h00, 32'h1234_5678, 32'h1234_5678, 1'b0, 1'b0);
      rg(AR, 8'h00, 32'h8765_4321, 32'h8765_4321, 1'b0, 1'b0);
      rg(LL, 8'h00, 32'h0000_1001, 32'h0000_1001, 1'b0, 1'b0);
      fs = 1'b0;
      rg(LR, 8'h01, 32'h8000_0000, 32'h4000_0000, 1'b0, 1'b0);
      im(bsou_pkg::BSOU_IMM_ROTATED, 8'hFF, 5'h18, 32'hFF00_0000, 1'b0, 1'b0);
   endtask : t_shift
   task automatic t_wr;
      @(negedge clk);
      wr = 1'b1;
      wv = ~cy;
      @(negedge clk);
      wr = 1'b0;
      cy = wv;
      chk(co, cy);
   endtask : t_wr
   task automatic t_prio;
      fs = 1'b1;
      wr = 1'b1;
      wv = 1'b0;
      cy = 1'b0;
      rg(LR, 8'h01, 32'h8000_0001, 32'h4000_0000, 1'b1, 1'b1);
      wr = 1'b0;
   endtask : t_prio
   task automatic t_rst;
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      cy = bsou_pkg::CARRY_RST;
      chk(rv, 1'b0);
      chk(res.operand, bsou_pkg::RESULT_RST);
      chk(res.carry_upd, 1'b0);
      chk(co, cy);
      rst = 1'b0;
   endtask : t_rst
   task automatic summarize;
      $display("fail_count %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   initial begin
      {vld, wr, wv, fs, cy} = 5'h00;
      req = '0;
      rst = 1'b1;
      fail_count = 0;
      compares = 0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_imm;
      t_shift;
      t_prio;
      t_wr;
      t_wr;
      t_rst;
      summarize;
   end
   initial begin
      repeat (500) @(posedge clk);
      fail_count++;
      summarize;
   end
endmodule : bsou_top_tb
